// [hdl/epd_dma.sv]
`timescale 1ns/1ps
// Notes on behaviour
// R1 - Eight identical channels, each with its own control and status registers.
// R2 - Transfers run on a dedicated DMA bus, never stalling the processor.
// R3 - Each channel may pick any of the DMA capable request sources.
// R4 - A channel interrupts when its block finishes, or at the half point.
// R5 - Control bit 12 set interrupts at half block, clear at full block.
// R6 - Control bit 15 enables the channel.
// R7 - Control bit 14 set moves bytes, clear moves 16-bit words.
// R8 - Control bit 13 set reads RAM writes peripheral; clear the reverse.
// R9 - Bit 11 with direction clear adds a null peripheral write per RAM write.
// R10 - Bits 5-4: post-increment, fixed, peripheral indirect, reserved.
// R11 - Peripheral indirect takes low RAM address bits from the peripheral.
// R12 - Bits 1-0 select continuous or one-shot, with or without ping-pong.
// R13 - One-shot stops after a single block, or after one block from each buffer with ping-pong.
// R14 - Continuous reloads the RAM base after each block and carries on.
// R15 - Ping-pong alternates primary and secondary bases on successive blocks.
// R16 - Writing 1 to request bit 15 forces exactly one transfer.
// R17 - Software cannot clear the force bit; hardware clears it when done.
// R18 - Request bits 6-0 choose one of 128 request numbers.
// R19 - Request numbers follow the fixed peripheral map of the system.
// R20 - Primary base holds the first or only buffer address.
// R21 - Secondary base holds the alternate ping-pong buffer address.
// R22 - A 10-bit count register sets the block length.
// R23 - A block holds count plus one transfers.
// R24 - Software should not rewrite address or count while enabled.
// R25 - Lowest numbered pending channel is served first.
// R26 - One-shot without ping-pong clears the enable when the block completes.
module epd_dma
	import epd_pkg::*;
#(
	parameter int NCH = EPD_NCH,
	parameter int NREQ = EPD_NREQ,
	parameter int IND_W = EPD_IND_W
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic [6:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	input wire logic [NREQ-1:0] periph_req,
	input wire logic [IND_W-1:0] periph_ind_addr,
	output logic [15:0] ram_addr,
	output logic ram_re,
	output logic ram_we,
	output logic [15:0] ram_wdata,
	input wire logic [15:0] ram_rdata,
	output logic [15:0] per_addr,
	output logic per_re,
	output logic per_we,
	output logic [15:0] per_wdata,
	input wire logic [15:0] per_rdata,
	output logic xfer_byte,
	output logic [NCH-1:0] blk_irq
);
	// Channel index is three bits wide and the trigger select seven
	if (NCH < 1 || NCH > 8 || NREQ != 128 || IND_W < 1 || IND_W > 15) begin : g_bad_param
		$error("epd_dma: unsupported parameter values");
	end

	typedef struct packed {
		epd_state_t st;
		logic [2:0] ch;
		logic forced;
		logic [NCH-1:0][15:0] ctrl;
		logic [NCH-1:0][15:0] req;
		logic [NCH-1:0][15:0] primary_base;
		logic [NCH-1:0][15:0] stb;
		logic [NCH-1:0][15:0] pad;
		logic [NCH-1:0][9:0] cnt;
		logic [NCH-1:0][15:0] cur;
		logic [NCH-1:0][9:0] xcnt;
		logic [NCH-1:0] ppst;
		logic [NCH-1:0] pend;
		logic [NCH-1:0] frc_pend;
		logic [3:0] last_ch;
		logic [15:0] rdata;
		logic [15:0] ram_addr;
		logic ram_re;
		logic ram_we;
		logic [15:0] ram_wdata;
		logic [15:0] per_addr;
		logic per_re;
		logic per_we;
		logic [15:0] per_wdata;
		logic byte_m;
		logic [NCH-1:0] irq;
	} epd_regs_t;

	epd_regs_t q, d;
	logic [NCH-1:0] hit;
	logic grant_v;
	logic [2:0] grant_ch;
	logic fin;
	logic blk_end;

	////////////////////////////////////////////////////////////////////////////
	// Trigger selection per channel
	genvar gi;
	generate
		for (gi = 0; gi < NCH; gi++) begin : g_trig
			assign hit[gi] = periph_req[q.req[gi][6:0]]; // R3 R18 R19
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		logic [1:0] am;
		logic [1:0] md;
		logic [15:0] step;
		logic [15:0] radr;
		logic [2:0] c;
		d = q;
		d.ram_re = 1'b0;
		d.ram_we = 1'b0;
		d.per_re = 1'b0;
		d.per_we = 1'b0;
		d.irq = '0;
		d.rdata = 16'h0000;
		grant_v = 1'b0;
		grant_ch = 3'h0;
		fin = 1'b0;
		blk_end = 1'b0;
		c = q.ch;
		am = q.ctrl[c][EPD_B_AM +: 2];
		md = q.ctrl[c][EPD_B_MODE +: 2];
		step = q.ctrl[c][EPD_B_BYTE] ? EPD_STEP_BYTE : EPD_STEP_WORD;
		radr = q.cur[c];
		if (am == EPD_AM_PIND) begin
			radr[IND_W-1:0] = periph_ind_addr; // R11
		end
		// Scan downward so the lowest enabled pending channel wins
		for (int i = NCH - 1; i >= 0; i--) begin
			if (q.pend[i] && q.ctrl[i][EPD_B_ON]) begin
				grant_v = 1'b1; // R25
				grant_ch = 3'(i);
			end
		end
		case (q.st)
			EPD_S_IDLE: begin
				if (grant_v) begin
					d.st = EPD_S_RD;
					d.ch = grant_ch;
					d.forced = q.frc_pend[grant_ch];
					d.pend[grant_ch] = 1'b0;
					d.frc_pend[grant_ch] = 1'b0;
				end
			end
			EPD_S_RD: begin
				d.st = EPD_S_CAP;
				d.byte_m = q.ctrl[c][EPD_B_BYTE]; // R7
				d.per_addr = q.pad[c];
				d.ram_addr = radr;
				if (q.ctrl[c][EPD_B_DIR]) begin
					d.ram_re = 1'b1; // R8
				end else begin
					d.per_re = 1'b1;
				end
			end
			EPD_S_CAP: begin
				d.st = EPD_S_WR;
			end
			EPD_S_WR: begin
				d.st = EPD_S_IDLE;
				if (q.ctrl[c][EPD_B_DIR]) begin
					d.per_we = 1'b1; // R8
					d.per_wdata = ram_rdata;
				end else begin
					d.ram_we = 1'b1;
					d.ram_wdata = per_rdata;
					d.per_we = q.ctrl[c][EPD_B_NULL]; // R9
					d.per_wdata = 16'h0000;
				end
				fin = 1'b1;
				d.last_ch = {1'b0, c};
				if (am == EPD_AM_INC) begin
					d.cur[c] = q.cur[c] + step; // R10
				end
				if (q.forced) begin
					d.req[c][EPD_B_FORCE] = 1'b0; // R17
				end
				if (q.xcnt[c] == q.cnt[c]) begin
					blk_end = 1'b1; // R23
					d.xcnt[c] = 10'h000;
					// A one-transfer block is its own half point
					d.irq[c] = !q.ctrl[c][EPD_B_HALF] || (q.cnt[c] == 10'h000); // R4 R5
					if (md[1]) begin
						d.ppst[c] = !q.ppst[c]; // R15
						d.cur[c] = q.ppst[c] ? q.primary_base[c] : q.stb[c]; // R20 R21
					end else begin
						d.cur[c] = q.primary_base[c]; // R14
					end
					if (md[0] && (!md[1] || q.ppst[c])) begin
						d.ctrl[c][EPD_B_ON] = 1'b0; // R13 R26
					end
				end else begin
					d.xcnt[c] = q.xcnt[c] + 10'h001; // R22
					d.irq[c] = q.ctrl[c][EPD_B_HALF] && (q.xcnt[c] == (q.cnt[c] >> 1)); // R5
				end
			end
			default: begin
				d.st = EPD_S_IDLE;
			end
		endcase
		// Requests arriving in the grant cycle are kept, except on a channel whose force is still pending
		d.pend = d.pend | (hit & ~q.frc_pend); // R3 R6
		for (int i = 0; i < NCH; i++) begin
			if (!q.ctrl[i][EPD_B_ON]) begin
				d.pend[i] = 1'b0; // R6
			end
			if (reg_wr && !reg_addr[6] && reg_addr[5:3] == 3'(i)) begin
				case (reg_addr[2:0])
					EPD_OFS_CTRL: begin
						d.ctrl[i] = reg_wdata & EPD_CTRL_MASK; // R1 R6 R12
						if (reg_wdata[EPD_B_ON] && !q.ctrl[i][EPD_B_ON]) begin
							d.cur[i] = q.primary_base[i];
							d.xcnt[i] = 10'h000;
							d.ppst[i] = 1'b0;
						end
					end
					EPD_OFS_REQ: begin
						d.req[i][6:0] = reg_wdata[6:0]; // R18
						// A zero in the force bit is ignored; a finished forced transfer clears it
						if (reg_wdata[EPD_B_FORCE]) begin
							d.req[i][EPD_B_FORCE] = 1'b1; // R16 R17
							d.pend[i] = 1'b1;
							d.frc_pend[i] = 1'b1;
						end
					end
					EPD_OFS_STA: d.primary_base[i] = reg_wdata; // R20
					EPD_OFS_STB: d.stb[i] = reg_wdata; // R21
					EPD_OFS_PAD: d.pad[i] = reg_wdata; // R24
					EPD_OFS_CNT: d.cnt[i] = reg_wdata[9:0]; // R22 R24
					default: begin
					end
				endcase
			end
		end
		if (reg_rd) begin
			if (reg_addr == EPD_ADR_HIST) begin
				d.rdata = {4'h0, q.last_ch, 8'(q.ppst)};
			end else if (!reg_addr[6] && {1'b0, reg_addr[5:3]} < 4'(NCH)) begin
				case (reg_addr[2:0])
					EPD_OFS_CTRL: d.rdata = q.ctrl[reg_addr[5:3]];
					EPD_OFS_REQ: d.rdata = q.req[reg_addr[5:3]] & EPD_REQ_MASK;
					EPD_OFS_STA: d.rdata = q.primary_base[reg_addr[5:3]];
					EPD_OFS_STB: d.rdata = q.stb[reg_addr[5:3]];
					EPD_OFS_PAD: d.rdata = q.pad[reg_addr[5:3]];
					EPD_OFS_CNT: d.rdata = {6'h00, q.cnt[reg_addr[5:3]]};
					default: d.rdata = 16'h0000;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			q <= '0;
			q.st <= EPD_S_IDLE;
			q.last_ch <= EPD_RST_LAST;
		end else begin
			q <= d;
		end
	end

	assign reg_rdata = q.rdata;
	assign ram_addr = q.ram_addr;
	assign ram_re = q.ram_re;
	assign ram_we = q.ram_we;
	assign ram_wdata = q.ram_wdata;
	assign per_addr = q.per_addr;
	assign per_re = q.per_re;
	assign per_we = q.per_we;
	assign per_wdata = q.per_wdata;
	assign xfer_byte = q.byte_m;
	assign blk_irq = q.irq;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!arst_n);

	property p_seq;
		q.st == EPD_S_RD |=> q.st == EPD_S_CAP ##1 q.st == EPD_S_WR ##1 (ram_we || per_we);
	endproperty
	a_seq: assert property (p_seq) else $error("transfer sequence broken"); // R2

	property p_grant_low;
		(q.st == EPD_S_IDLE && grant_v) |->
			((q.pend & (NCH'(1) << grant_ch) - NCH'(1)) == '0);
	endproperty
	a_grant_low: assert property (p_grant_low) else $error("lower channel skipped"); // R25

	property p_enabled;
		(q.st == EPD_S_IDLE && grant_v) |-> q.ctrl[grant_ch][EPD_B_ON];
	endproperty
	a_enabled: assert property (p_enabled) else $error("disabled channel served"); // R6

	property p_byte;
		ram_we |-> xfer_byte == q.ctrl[q.ch][EPD_B_BYTE];
	endproperty
	a_byte: assert property (p_byte) else $error("transfer size mismatch"); // R7

	property p_dir;
		(q.st == EPD_S_CAP) |-> (ram_re == q.ctrl[q.ch][EPD_B_DIR]) && (per_re != ram_re);
	endproperty
	a_dir: assert property (p_dir) else $error("direction mismatch"); // R8

	property p_null;
		(ram_we && per_we) |-> per_wdata == 16'h0000 && q.ctrl[q.ch][EPD_B_NULL];
	endproperty
	a_null: assert property (p_null) else $error("null write wrong"); // R9

	property p_inc;
		(fin && !blk_end && q.ctrl[q.ch][EPD_B_AM +: 2] == EPD_AM_INC) |=>
			q.cur[$past(q.ch)] == $past(q.cur[q.ch]) + (q.byte_m ? 16'h0001 : 16'h0002);
	endproperty
	a_inc: assert property (p_inc) else $error("post increment wrong"); // R10

	property p_oneshot;
		(fin && blk_end && q.ctrl[q.ch][EPD_B_MODE +: 2] == 2'b01) |=>
			!q.ctrl[$past(q.ch)][EPD_B_ON] || $past(reg_wr);
	endproperty
	a_oneshot: assert property (p_oneshot) else $error("one-shot did not stop"); // R13 R26

	property p_irq;
		(blk_irq != '0) |-> $past(fin);
	endproperty
	a_irq: assert property (p_irq) else $error("stray interrupt"); // R4

	property p_force;
		(fin && q.forced) |=> !q.req[$past(q.ch)][EPD_B_FORCE] || $past(reg_wr);
	endproperty
	a_force: assert property (p_force) else $error("force bit not cleared"); // R17

	property p_rdata_idle;
		!$past(reg_rd) |-> reg_rdata == 16'h0000;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside a read"); // R1

	property p_half;
		(fin && q.ctrl[q.ch][EPD_B_HALF] && q.xcnt[q.ch] == (q.cnt[q.ch] >> 1)) |=>
			blk_irq[$past(q.ch)];
	endproperty
	a_half: assert property (p_half) else $error("half block interrupt missing"); // R5

	property p_pingpong;
		(fin && blk_end && q.ctrl[q.ch][EPD_B_MODE + 1]) |=>
			(q.ppst[$past(q.ch)] != $past(q.ppst[q.ch])) || $past(reg_wr);
	endproperty
	a_pingpong: assert property (p_pingpong) else $error("buffer did not swap"); // R15

	property p_reload;
		(fin && blk_end && q.ctrl[q.ch][EPD_B_MODE +: 2] == 2'h0) |=>
			(q.cur[$past(q.ch)] == $past(q.primary_base[q.ch])) || $past(reg_wr);
	endproperty
	a_reload: assert property (p_reload) else $error("base not reloaded"); // R14

	property p_block_len;
		(fin && blk_end) |=> q.xcnt[$past(q.ch)] == 10'h000;
	endproperty
	a_block_len: assert property (p_block_len) else $error("count not restarted"); // R23

	// Main scenarios
	c_block: cover property (fin && blk_end);
	c_pingpong: cover property (fin && blk_end && q.ctrl[q.ch][1]);
	c_null: cover property (ram_we && per_we);
	c_force: cover property (fin && q.forced);
	c_indirect: cover property (fin && q.ctrl[q.ch][EPD_B_AM +: 2] == EPD_AM_PIND);
endmodule

// [pkg/epd_pkg.sv]
package epd_pkg;
	localparam int EPD_NCH = 8;
	localparam int EPD_NREQ = 128;
	localparam int EPD_IND_W = 8;
	localparam logic [2:0] EPD_OFS_CTRL = 3'h0;
	localparam logic [2:0] EPD_OFS_REQ = 3'h1;
	localparam logic [2:0] EPD_OFS_STA = 3'h2;
	localparam logic [2:0] EPD_OFS_STB = 3'h3;
	localparam logic [2:0] EPD_OFS_PAD = 3'h4;
	localparam logic [2:0] EPD_OFS_CNT = 3'h5;
	localparam logic [6:0] EPD_ADR_HIST = 7'h40;
	localparam int EPD_B_ON = 15;
	localparam int EPD_B_BYTE = 14;
	localparam int EPD_B_DIR = 13;
	localparam int EPD_B_HALF = 12;
	localparam int EPD_B_NULL = 11;
	localparam int EPD_B_AM = 4;
	localparam int EPD_B_MODE = 0;
	localparam int EPD_B_FORCE = 15;
	localparam logic [15:0] EPD_CTRL_MASK = 16'hf833;
	localparam logic [15:0] EPD_REQ_MASK = 16'h807f;
	localparam logic [15:0] EPD_CNT_MASK = 16'h03ff;
	localparam logic [15:0] EPD_RST_REG = 16'h0000;
	localparam logic [3:0] EPD_RST_LAST = 4'hf;
	localparam logic [1:0] EPD_AM_INC = 2'h0;
	localparam logic [1:0] EPD_AM_FIX = 2'h1;
	localparam logic [1:0] EPD_AM_PIND = 2'h2;
	localparam logic [15:0] EPD_STEP_WORD = 16'h0002;
	localparam logic [15:0] EPD_STEP_BYTE = 16'h0001;
	typedef enum logic [1:0] {
		EPD_S_IDLE = 2'b00,
		EPD_S_RD = 2'b01,
		EPD_S_CAP = 2'b10,
		EPD_S_WR = 2'b11
	} epd_state_t;
endpackage

// [testbench/epd_dma_tb.sv]
`timescale 1ns/1ps
module epd_dma_tb
	import epd_pkg::*;
;
	logic clk_sys, arst_n, reg_wr, reg_rd, fire, rd_p, ram_re, ram_we, per_re, per_we, xfer_byte;
	logic [6:0] reg_addr, fire_num, t;
	logic [15:0] reg_wdata, reg_rdata, ram_addr, ram_wdata, ram_rdata, per_addr, per_wdata;
	logic [15:0] per_rdata, primary_base, stb, pad;
	logic [15:0] v[8];
	logic [127:0] periph_req;
	logic [7:0] ind, blk_irq;
	logic [15:0] rq[$];
	logic [32:0] mq[$], pq[$];
	logic [7:0] iq[$];
	int err_total, checks;

	epd_dma dut (.clk_sys, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.periph_req, .periph_ind_addr(ind), .ram_addr, .ram_re, .ram_we, .ram_wdata,
		.ram_rdata, .per_addr, .per_re, .per_we, .per_wdata, .per_rdata, .xfer_byte,
		.blk_irq);
	epd_far_model far (.clk_sys, .arst_n, .fire, .fire_num, .periph_req, .ram_addr,
		.ram_re, .ram_rdata, .per_addr, .per_re, .per_rdata);

	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
////////////////////////////////
	task automatic cmp(input string what, input logic [32:0] e, input logic [32:0] g);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, e, g);
		end
	endtask
	// Byte transfers only promise the low byte
	task automatic cmp_xfer(input string what, input logic [32:0] e, input logic [32:0] g);
		if (e[32] === 1'b1) begin
			e[15:8] = 8'h00;
			g[15:8] = 8'h00;
		end
		cmp(what, e, g);
	endtask
	task automatic bus(input logic w, input logic [6:0] a, input logic [15:0] d);
		reg_wr <= w;
		reg_rd <= ~w;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
	endtask
	task automatic wr(input logic [2:0] c, input logic [2:0] r, input logic [15:0] d);
		bus(1'b1, {1'b0, c, r}, d);
	endtask
	task automatic rd(input logic [6:0] a, input logic [15:0] e);
		rq.push_back(e);
		bus(1'b0, a, 16'h0000);
	endtask
	task automatic idle(input int n);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		fire <= 1'b0;
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic trig(input logic [6:0] n);
		fire_num <= n;
		fire <= 1'b1;
		@(posedge clk_sys);
		idle(8);
	endtask
	task automatic settle(input string name);
		int n;
		idle(2);
		n = 0;
		while (mq.size() + pq.size() + iq.size() + rq.size() != 0 && n < 100) begin
			@(posedge clk_sys);
			n++;
		end
		idle(6);
		cmp("notes left", 33'h0, 33'(mq.size() + pq.size() + iq.size() + rq.size()));
		$display("Test %s done", name);
	endtask
	task automatic close_out();
		$display("Checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
////////////////////////////////
	always @(posedge clk_sys) begin
		if (rd_p)
			cmp("rdata", rq.size() ? {17'h0, rq.pop_front()} : 'x, {17'h0, reg_rdata});
		if (ram_we)
			cmp_xfer("ram", mq.size() ? mq.pop_front() : 'x, {xfer_byte, ram_addr, ram_wdata});
		if (per_we)
			cmp_xfer("per", pq.size() ? pq.pop_front() : 'x, {xfer_byte, per_addr, per_wdata});
		if (blk_irq !== 8'h00)
			cmp("irq", iq.size() ? {25'h0, iq.pop_front()} : 'x, {25'h0, blk_irq});
		rd_p = reg_rd;
	end
	// Bound is far above the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge clk_sys);
		err_total++;
		close_out();
	end
	initial begin
		arst_n = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 7'h00;
		reg_wdata = 16'h0000;
		fire = 1'b0;
		fire_num = 7'h00;
		ind = 8'h00;
		rd_p = 1'b0;
		void'($urandom(32'ha839));
		repeat (3) @(posedge clk_sys);
		arst_n <= 1'b1;
		@(posedge clk_sys);
		primary_base = 16'($urandom) & 16'hfff0;
		pad = 16'($urandom);
		stb = 16'($urandom);
		ind <= 8'($urandom);
		t = 7'($urandom % 127);
		rd(EPD_ADR_HIST, 16'h0f00);
		wr(3'h7, EPD_OFS_CTRL, 16'h7fff);
		wr(3'h7, EPD_OFS_REQ, 16'h7fff);
		wr(3'h7, EPD_OFS_CNT, 16'hffff);
		for (int c = 0; c < 8; c++) begin
			v[c] = 16'($urandom);
			wr(3'(c), EPD_OFS_STB, v[c]);
		end
		for (int c = 0; c < 8; c++) rd({1'b0, 3'(c), EPD_OFS_STB}, v[c]);
		rd({1'b0, 3'h7, EPD_OFS_CTRL}, 16'h7833);
		rd({1'b0, 3'h7, EPD_OFS_REQ}, 16'h007f);
		rd({1'b0, 3'h7, EPD_OFS_CNT}, 16'h03ff);
		rd(7'h41, 16'h0000);
		settle("registers");
		wr(3'h2, EPD_OFS_REQ, {9'h000, t});
		wr(3'h2, EPD_OFS_STA, primary_base);
		wr(3'h2, EPD_OFS_PAD, pad);
		wr(3'h2, EPD_OFS_CNT, 16'h0002);
		wr(3'h2, EPD_OFS_CTRL, 16'h9001);
		idle(2);
		for (int i = 0; i < 3; i++) mq.push_back({1'b0, primary_base + 16'(2 * i), pad ^ 16'h3c5a});
		iq.push_back(8'h04);
		trig(t ^ 7'h01);
		repeat (4) trig(t);
		settle("one-shot block");
		rd({1'b0, 3'h2, EPD_OFS_CTRL}, 16'h1001);
		settle("auto disable");
		wr(3'h0, EPD_OFS_PAD, pad);
		wr(3'h0, EPD_OFS_STA, primary_base);
		wr(3'h0, EPD_OFS_CNT, 16'h0000);
		wr(3'h0, EPD_OFS_CTRL, 16'he010);
		for (int k = 0; k < 2; k++) begin
			pq.push_back({1'b1, pad, primary_base ^ 16'hc3a5});
			iq.push_back(8'h01);
			wr(3'h0, EPD_OFS_REQ, 16'h807f);
			idle(10);
			rd({1'b0, 3'h0, EPD_OFS_REQ}, 16'h007f);
		end
		settle("forced transfers");
		wr(3'h6, EPD_OFS_REQ, {9'h000, t});
		wr(3'h6, EPD_OFS_STA, primary_base);
		wr(3'h6, EPD_OFS_STB, stb);
		wr(3'h6, EPD_OFS_PAD, pad);
		wr(3'h6, EPD_OFS_CNT, 16'h0000);
		wr(3'h6, EPD_OFS_CTRL, 16'h8823);
		idle(2);
		mq.push_back({1'b0, primary_base[15:8], ind, pad ^ 16'h3c5a});
		mq.push_back({1'b0, stb[15:8], ind, pad ^ 16'h3c5a});
		for (int k = 0; k < 2; k++) begin
			pq.push_back({1'b0, pad, 16'h0000});
			iq.push_back(8'h40);
		end
		repeat (3) trig(t);
		settle("ping-pong null write");
		rd({1'b0, 3'h6, EPD_OFS_CTRL}, 16'h0823);
		settle("ping-pong stop");
		wr(3'h0, EPD_OFS_REQ, {9'h000, t});
		wr(3'h2, EPD_OFS_CTRL, 16'h9001);
		idle(2);
		pq.push_back({1'b1, pad, primary_base ^ 16'hc3a5});
		iq.push_back(8'h01);
		mq.push_back({1'b0, primary_base, pad ^ 16'h3c5a});
		trig(t);
		idle(4);
		rd(EPD_ADR_HIST, 16'h0200);
		settle("priority");
		close_out();
	end
endmodule

// [testbench/epd_far_model.sv]
`timescale 1ns/1ps
module epd_far_model (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic fire,
	input wire logic [6:0] fire_num,
	output logic [127:0] periph_req,
	input wire logic [15:0] ram_addr,
	input wire logic ram_re,
	output logic [15:0] ram_rdata,
	input wire logic [15:0] per_addr,
	input wire logic per_re,
	output logic [15:0] per_rdata
);
	// Read data toggle outside a read so stale data never passes for fresh
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			periph_req <= '0;
			ram_rdata <= 16'h0000;
			per_rdata <= 16'h0000;
		end else begin
			periph_req <= fire ? (128'h1 << fire_num) : '0;
			ram_rdata <= ram_re ? (ram_addr ^ 16'hc3a5) : ~ram_rdata;
			per_rdata <= per_re ? (per_addr ^ 16'h3c5a) : ~per_rdata;
		end
	end
endmodule
